/* File: rtl/acs_top.sv */
// Address match memory, port synchronizer and management timer
`timescale 1ns/1ps
module acs_top
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // MAC receive pins
    input wire logic byte_clock,
    input wire logic [acs_pkg::BYTE_W-1:0] receive_data_bus,
    input wire logic addr_load,
    input wire logic extended_match,
    // Match memory host command
    input wire logic cam_cmd_valid,
    input wire acs_pkg::acs_cam_op_t cam_cmd_op,
    input wire logic [acs_pkg::CAM_IDX_W-1:0] cam_cmd_index,
    input wire logic [acs_pkg::CAM_W-1:0] cam_cmd_data,
    input wire logic cam_cmd_set_valid,
    // Match memory host answer
    output logic cam_rsp_valid,
    output logic [acs_pkg::CAM_W-1:0] cam_rsp_data,
    output logic cam_rsp_entry_valid,
    output logic cam_rsp_hit,
    output logic [acs_pkg::CAM_IDX_W-1:0] cam_rsp_index,
    // Receive address match result
    output logic cam_match_hit,
    output logic [acs_pkg::CAM_IDX_W-1:0] cam_match_index,
    output logic cam_match_src,
    // Synchronized receive data to the system interface
    output logic [acs_pkg::BYTE_W-1:0] sysif_rx_data,
    output logic sysif_rx_valid,
    output logic sysif_rx_start,
    // Management timer access
    input wire logic timer_load_low_wr,
    input wire logic timer_load_high_wr,
    input wire logic timer_value_low_rd,
    input wire logic timer_value_high_rd,
    input wire logic [acs_pkg::TMR_HALF-1:0] timer_wdata,
    input wire logic timer_flag_clr,
    input wire logic timer_irq_en,
    output logic [acs_pkg::TMR_HALF-1:0] timer_rdata,
    output logic timer_expired_flag,
    output logic timer_irq,
    // MAC register access sources
    input wire logic porta_wr,
    input wire logic [acs_pkg::MREG_ADDR_W-1:0] porta_addr,
    input wire logic [acs_pkg::MREG_DATA_W-1:0] porta_wdata,
    input wire logic sysif_ctl_wr,
    input wire logic [acs_pkg::MREG_ADDR_W-1:0] sysif_ctl_addr,
    input wire logic [acs_pkg::MREG_DATA_W-1:0] sysif_ctl_wdata,
    input wire logic ctlcmd_wr,
    input wire logic [acs_pkg::MREG_ADDR_W-1:0] ctlcmd_addr,
    input wire logic [acs_pkg::MREG_DATA_W-1:0] ctlcmd_wdata,
    // MAC register write port
    output logic macreg_wr,
    output logic [acs_pkg::MREG_ADDR_W-1:0] macreg_addr,
    output logic [acs_pkg::MREG_DATA_W-1:0] macreg_wdata,
    output logic [2:0] macreg_ack
);
    import acs_pkg::*;

    // ======================================================
    // Storage and state
    logic [CAM_W-1:0] mem [CAM_ENTRIES];
    logic [CAM_ENTRIES-1:0] valid_q;
    acs_match_st_t st_q;
    logic [2:0] bcnt_q;
    logic [CAM_W-1:0] sr_q;
    logic ext_s1_q, ext_s2_q;
    logic [CAM_W-1:0] key_w;
    logic last_w;
    acs_match_t rx_m_w, cmd_m_w;
    logic cmd_wr_w, cmd_clr_w;

    acs_rx_if rx ();

    // ======================================================
    // Lowest valid entry equal to the key; shared by both compares
    function automatic acs_match_t find_entry(
        input logic [CAM_W-1:0] key);
        acs_match_t r;
        r = '0;
        for (int i = CAM_ENTRIES - 1; i >= 0; i--) begin
            if (valid_q[i] && mem[i] == key) begin
                r.hit = 1'b1;
                r.idx = CAM_IDX_W'(i);
            end
        end
        return r;
    endfunction

    // ======================================================
    // Synchronizer and timer
    // receive bytes enter the mclk domain here
    acs_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .byte_clock(byte_clock),
        .receive_data_bus(receive_data_bus),
        .addr_load(addr_load),
        .rx(rx)
    );

    acs_timer u_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .rx(rx),
        .ld_lo_wr(timer_load_low_wr),
        .ld_hi_wr(timer_load_high_wr),
        .val_lo_rd(timer_value_low_rd),
        .val_hi_rd(timer_value_high_rd),
        .wdata(timer_wdata),
        .flag_clr(timer_flag_clr),
        .irq_en(timer_irq_en),
        .rdata(timer_rdata),
        .expired(timer_expired_flag),
        .irq(timer_irq)
    );

    // ======================================================
    // Forward synchronized bytes to the system interface
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sysif_rx_data <= '0;
            sysif_rx_valid <= 1'b0;
            sysif_rx_start <= 1'b0;
        end else begin
            sysif_rx_valid <= rx.stb;
            sysif_rx_start <= rx.stb & rx.load;
            if (rx.stb)
                sysif_rx_data <= rx.data;
        end
    end

    // Match mode pin comes from the MAC; synchronized before use
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            ext_s1_q <= extended_match;
            ext_s2_q <= ext_s1_q;
        end
    end

    // ======================================================
    // Host command decode
    assign cmd_wr_w = cam_cmd_valid && cam_cmd_op == ACS_OP_WRITE;
    assign cmd_clr_w = cam_cmd_valid && cam_cmd_op == ACS_OP_CLEAR;
    assign cmd_m_w = find_entry(cam_cmd_data);

    // data array needs no reset; validity guards it
    always_ff @(posedge mclk) begin
        if (cmd_wr_w)
            mem[cam_cmd_index] <= cam_cmd_data;
    end

    for (genvar g = 0; g < CAM_ENTRIES; g++) begin : g_valid
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                valid_q[g] <= 1'b0;
            end else if (cam_cmd_index == CAM_IDX_W'(g)) begin
                // write sets or clears, clear always clears
                if (cmd_wr_w)
                    valid_q[g] <= cam_cmd_set_valid;
                else if (cmd_clr_w)
                    valid_q[g] <= 1'b0;
            end
        end
    end

    // ======================================================
    // Host answer, one cycle after the command
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cam_rsp_valid <= 1'b0;
            cam_rsp_data <= '0;
            cam_rsp_entry_valid <= 1'b0;
            cam_rsp_hit <= 1'b0;
            cam_rsp_index <= '0;
        end else begin
            cam_rsp_valid <= cam_cmd_valid;
            case (cam_cmd_op)
                ACS_OP_READ: begin
                    cam_rsp_data <= mem[cam_cmd_index];
                    cam_rsp_entry_valid <= valid_q[cam_cmd_index];
                    cam_rsp_index <= cam_cmd_index;
                    cam_rsp_hit <= 1'b0;
                end
                ACS_OP_COMPARE: begin
                    cam_rsp_data <= cam_cmd_data;
                    cam_rsp_entry_valid <= 1'b0;
                    cam_rsp_hit <= cmd_m_w.hit;
                    cam_rsp_index <= cmd_m_w.idx;
                end
                default: begin
                    cam_rsp_data <= cam_cmd_data;
                    cam_rsp_entry_valid <= cmd_wr_w & cam_cmd_set_valid;
                    cam_rsp_hit <= 1'b0;
                    cam_rsp_index <= cam_cmd_index;
                end
            endcase
        end
    end

    // ======================================================
    // Receive address assembly, most significant byte first
    assign key_w = {sr_q[CAM_W-BYTE_W-1:0], rx.data};
    assign last_w = rx.stb && bcnt_q == ADDR_LAST
        && (st_q == ACS_ST_DA || st_q == ACS_ST_SA);
    assign rx_m_w = find_entry(key_w);

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ACS_ST_IDLE;
            bcnt_q <= ADDR_ZERO;
            sr_q <= '0;
        end else if (rx.stb) begin
            sr_q <= key_w;
            if (rx.load) begin
                // load strobe opens the destination field
                st_q <= ACS_ST_DA;
                bcnt_q <= ADDR_FIRST;
            end else begin
                case (st_q)
                    ACS_ST_DA: begin
                        bcnt_q <= last_w ? ADDR_ZERO : bcnt_q + 1'b1;
                        // normal mode goes on to the source
                        if (last_w)
                            st_q <= ext_s2_q ? ACS_ST_IDLE : ACS_ST_SA;
                    end
                    ACS_ST_SA: begin
                        bcnt_q <= last_w ? ADDR_ZERO : bcnt_q + 1'b1;
                        if (last_w)
                            st_q <= ACS_ST_IDLE;
                    end
                    ACS_ST_IDLE: begin
                        bcnt_q <= ADDR_ZERO;
                    end
                    default: begin
                        st_q <= ACS_ST_IDLE;
                        bcnt_q <= ADDR_ZERO;
                    end
                endcase
            end
        end
    end

    // hit pulse when an assembled address matches
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cam_match_hit <= 1'b0;
            cam_match_index <= '0;
            cam_match_src <= 1'b0;
        end else begin
            cam_match_hit <= last_w && !rx.load && rx_m_w.hit;
            if (last_w && !rx.load && rx_m_w.hit) begin
                cam_match_index <= rx_m_w.idx;
                cam_match_src <= st_q == ACS_ST_SA;
            end
        end
    end

    // ======================================================
    // MAC register paths: port A first, then control reg, then command
    // Requesters hold their strobe until acknowledged.
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            macreg_wr <= 1'b0;
            macreg_addr <= '0;
            macreg_wdata <= '0;
            macreg_ack <= 3'h0;
        end else begin
            // three sources share one write port
            macreg_wr <= porta_wr | sysif_ctl_wr | ctlcmd_wr;
            if (porta_wr) begin
                macreg_addr <= porta_addr;
                macreg_wdata <= porta_wdata;
                macreg_ack <= 3'h1;
            end else if (sysif_ctl_wr) begin
                macreg_addr <= sysif_ctl_addr;
                macreg_wdata <= sysif_ctl_wdata;
                macreg_ack <= 3'h2;
            end else if (ctlcmd_wr) begin
                macreg_addr <= ctlcmd_addr;
                macreg_wdata <= ctlcmd_wdata;
                macreg_ack <= 3'h4;
            end else begin
                macreg_ack <= 3'h0;
            end
        end
    end

    // ======================================================
    // Checks
    sequence s_da_done;
        rx.stb && st_q == ACS_ST_DA && bcnt_q == ADDR_LAST && !rx.load;
    endsequence

    a_match_ext: assert property (@(posedge mclk) disable iff (!reset_n)
        s_da_done and ext_s2_q |=> st_q == ACS_ST_IDLE)
        else $error("extended mode did not stop after destination");
    a_match_norm: assert property (@(posedge mclk) disable iff (!reset_n)
        s_da_done and !ext_s2_q |=> st_q == ACS_ST_SA)
        else $error("normal mode skipped source address");
    a_match_hit: assert property (@(posedge mclk) disable iff (!reset_n)
        last_w && !rx.load |=> cam_match_hit == $past(rx_m_w.hit))
        else $error("match hit does not follow compare");
    a_cam_write: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_wr_w |=> valid_q[$past(cam_cmd_index)]
            == $past(cam_cmd_set_valid)
            && mem[$past(cam_cmd_index)] == $past(cam_cmd_data))
        else $error("write did not update entry");
    a_cam_read: assert property (@(posedge mclk) disable iff (!reset_n)
        cam_cmd_valid && cam_cmd_op == ACS_OP_READ
        |=> cam_rsp_valid && cam_rsp_data == $past(mem[cam_cmd_index]))
        else $error("read answer wrong");
    a_cam_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        cmd_clr_w |=> !valid_q[$past(cam_cmd_index)])
        else $error("clear left entry valid");
    a_cam_reset: assert property (@(posedge mclk)
        $rose(reset_n) |-> valid_q == '0)
        else $error("entries valid after reset");
    a_path_prio: assert property (@(posedge mclk) disable iff (!reset_n)
        porta_wr |=> macreg_wr && macreg_ack == 3'h1
            && macreg_addr == $past(porta_addr))
        else $error("port A write not given priority");
endmodule

/* File: inc/acs_pkg.sv */
// Shared constants and types for the address match, sync and timer block
package acs_pkg;
    // ======================================================
    // Address match memory
    localparam int CAM_ENTRIES = 64;
    localparam int CAM_IDX_W = 6;
    localparam int CAM_W = 48;
    localparam int BYTE_W = 8;
    localparam logic [2:0] ADDR_LAST = 3'h5;
    localparam logic [2:0] ADDR_FIRST = 3'h1;
    localparam logic [2:0] ADDR_ZERO = 3'h0;
    // ======================================================
    // Management timer: 512 byte clocks per decrement
    localparam int PRE_W = 9;
    localparam logic [PRE_W-1:0] PRE_LAST = 9'h1FF;
    localparam logic [PRE_W-1:0] PRE_ZERO = 9'h000;
    localparam int TMR_W = 16;
    localparam int TMR_HALF = 8;
    localparam logic [TMR_W-1:0] TMR_ONE = 16'h0001;
    // ======================================================
    // MAC internal register access paths
    localparam int MREG_ADDR_W = 8;
    localparam int MREG_DATA_W = 16;
    // ======================================================
    // Types
    typedef enum logic [3:0] {
        ACS_OP_WRITE = 4'h1,
        ACS_OP_READ = 4'h2,
        ACS_OP_CLEAR = 4'h4,
        ACS_OP_COMPARE = 4'h8
    } acs_cam_op_t;
    typedef enum logic [2:0] {
        ACS_ST_IDLE = 3'h1,
        ACS_ST_DA = 3'h2,
        ACS_ST_SA = 3'h4
    } acs_match_st_t;
    typedef struct packed {
        logic hit;
        logic [CAM_IDX_W-1:0] idx;
    } acs_match_t;
endpackage

/* File: inc/acs_rx_if.sv */
// Receive bytes handed from the port synchronizer to its users
`timescale 1ns/1ps
interface acs_rx_if;
    logic [7:0] data;
    logic stb;
    logic load;
    modport src (output data, output stb, output load);
    modport dst (input data, input stb, input load);
endinterface

/* File: rtl/acs_sync.sv */
// Port synchronizer: byte clock and receive bus into the mclk domain
`timescale 1ns/1ps
module acs_sync
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // MAC receive pins
    input wire logic byte_clock,
    input wire logic [acs_pkg::BYTE_W-1:0] receive_data_bus,
    input wire logic addr_load,
    // Synchronized bytes
    acs_rx_if.src rx
);
    logic bclk_s1_q, bclk_s2_q, bclk_s3_q;
    logic [BYTE_W-1:0] data_s1_q, data_s2_q;
    logic load_s1_q, load_s2_q;
    logic edge_w;

    // ======================================================
    // Two-flop synchronizers; first stage feeds the second only
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            bclk_s1_q <= 1'b0;
            bclk_s2_q <= 1'b0;
            bclk_s3_q <= 1'b0;
            data_s1_q <= '0;
            data_s2_q <= '0;
            load_s1_q <= 1'b0;
            load_s2_q <= 1'b0;
        end else begin
            bclk_s1_q <= byte_clock;
            bclk_s2_q <= bclk_s1_q;
            bclk_s3_q <= bclk_s2_q;
            data_s1_q <= receive_data_bus;
            data_s2_q <= data_s1_q;
            load_s1_q <= addr_load;
            load_s2_q <= load_s1_q;
        end
    end

    // mclk no slower than symbol clock, so every edge is seen
    assign edge_w = bclk_s2_q & ~bclk_s3_q;

    // capture on the byte edge, about three mclk after the pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx.stb <= 1'b0;
            rx.data <= '0;
            rx.load <= 1'b0;
        end else begin
            rx.stb <= edge_w;
            if (edge_w) begin
                rx.data <= data_s2_q;
                rx.load <= load_s2_q;
            end
        end
    end

    a_sync_strobe: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(bclk_s2_q) |=> rx.stb ##1 !rx.stb)
        else $error("byte strobe not one cycle after edge");
endmodule

/* File: rtl/acs_timer.sv */
// Management countdown timer ticking every 512 byte clocks
`timescale 1ns/1ps
module acs_timer
    import acs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Byte clock ticks
    acs_rx_if.dst rx,
    // Software access strobes
    input wire logic ld_lo_wr,
    input wire logic ld_hi_wr,
    input wire logic val_lo_rd,
    input wire logic val_hi_rd,
    input wire logic [acs_pkg::TMR_HALF-1:0] wdata,
    input wire logic flag_clr,
    input wire logic irq_en,
    // Results
    output logic [acs_pkg::TMR_HALF-1:0] rdata,
    output logic expired,
    output logic irq
);
    logic [TMR_W-1:0] load_q, cnt_q;
    logic [PRE_W-1:0] pre_q;
    logic run_q, tick_w, expire_w;

    assign tick_w = run_q & rx.stb & (pre_q == PRE_LAST);
    assign expire_w = tick_w & (cnt_q == TMR_ONE);

    // ======================================================
    // Load value halves
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            load_q <= '0;
        end else begin
            if (ld_lo_wr)
                load_q[TMR_HALF-1:0] <= wdata;
            if (ld_hi_wr)
                load_q[TMR_W-1:TMR_HALF] <= wdata;
        end
    end

    // ======================================================
    // Count, prescale and run state
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= '0;
            pre_q <= PRE_ZERO;
            run_q <= 1'b0;
        end else if (ld_hi_wr) begin
            // high write loads both halves and starts
            cnt_q <= {wdata, load_q[TMR_HALF-1:0]};
            pre_q <= PRE_ZERO;
            run_q <= 1'b1;
        end else if (val_lo_rd || val_hi_rd) begin
            // a value read freezes the count
            // run_q stays low until the next high write
            run_q <= 1'b0;
        end else if (run_q && rx.stb) begin
            // one decrement per 512 byte clocks
            pre_q <= pre_q + 1'b1;
            if (expire_w)
                cnt_q <= load_q;
            else if (tick_w)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // ======================================================
    // Read data and expiry flag; a set beats a clear
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= '0;
            expired <= 1'b0;
            irq <= 1'b0;
        end else begin
            if (val_lo_rd)
                rdata <= cnt_q[TMR_HALF-1:0];
            else if (val_hi_rd)
                rdata <= cnt_q[TMR_W-1:TMR_HALF];
            // expiry sets the flag, gated onto irq
            if (expire_w)
                expired <= 1'b1;
            else if (flag_clr)
                expired <= 1'b0;
            irq <= (expired | expire_w) & irq_en;
        end
    end

    a_tmr_reload: assert property (@(posedge mclk) disable iff (!reset_n)
        expire_w && !ld_hi_wr && !val_lo_rd && !val_hi_rd
        |=> cnt_q == $past(load_q) && expired)
        else $error("expiry did not reload and flag");
    a_tmr_stop_read: assert property (@(posedge mclk) disable iff (!reset_n)
        (val_lo_rd || val_hi_rd) && !ld_hi_wr
        |=> !run_q ##1 (!run_q || $past(ld_hi_wr)))
        else $error("timer still runs after read");
    a_tmr_halt_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !run_q && !ld_hi_wr |=> $stable(cnt_q) && !expire_w)
        else $error("stopped timer moved");
    a_tmr_low_store: assert property (@(posedge mclk) disable iff (!reset_n)
        ld_lo_wr && !ld_hi_wr && !rx.stb |=> $stable(cnt_q))
        else $error("low load write disturbed count");
    a_tmr_decrement: assert property (@(posedge mclk) disable iff (!reset_n)
        tick_w && !expire_w && !ld_hi_wr && !val_lo_rd && !val_hi_rd
        |=> cnt_q == $past(cnt_q) - TMR_ONE && pre_q == PRE_ZERO)
        else $error("decrement not on prescale wrap");
    a_tmr_start: assert property (@(posedge mclk) disable iff (!reset_n)
        ld_hi_wr |=> run_q && cnt_q[TMR_W-1:TMR_HALF] == $past(wdata))
        else $error("high load write did not start");
endmodule

/* File: verif/acs_mac_model.sv */
// Behavioural MAC receive side driving the byte clock and receive bus
`timescale 1ns/1ps
module acs_mac_model (
    // Receive pins
    output logic byte_clock,
    output logic [7:0] receive_data_bus,
    output logic addr_load
);
    initial begin
        byte_clock = 1'b0;
        receive_data_bus = 8'h00;
        addr_load = 1'b0;
    end
    // slow byte clock
    // Each phase is about 4 mclk periods (37 ns high, 43 ns low), so the system clock stays faster
    task automatic send(input logic [7:0] b, input logic ld);
        #3 receive_data_bus = b;
        addr_load = ld;
        #40 byte_clock = 1'b1;
        #37 byte_clock = 1'b0;
        receive_data_bus = ~b; // Stale hold shows a changed value
        addr_load = 1'b0;
    endtask
endmodule

/* File: verif/testbench.sv */
// Self-checking bench for the match memory, synchronizer and timer
`timescale 1ns/1ps
module testbench;
    import acs_pkg::*;
    logic mclk, reset_n, ext, cv, sv, bc, ld;
    logic [7:0] rb, wd, sd, trd, ma;
    logic [3:0] op, tst;
    logic [5:0] ix, mi, ri;
    logic [47:0] cd, rd;
    logic [2:0] ack, rq;
    logic [15:0] qd;
    logic rv, rev, rh, mh, ms, ef, irq, ie, fc, rs, rxv, mw;
    int err_total, checks_done, hits, cyc, starts, rx_bytes;
    acs_mac_model u_mac (.byte_clock(bc), .receive_data_bus(rb),
        .addr_load(ld));
    acs_top u_dut (.mclk(mclk), .reset_n(reset_n), .byte_clock(bc),
        .receive_data_bus(rb), .addr_load(ld), .extended_match(ext),
        .cam_cmd_valid(cv), .cam_cmd_op(acs_cam_op_t'(op)),
        .cam_cmd_index(ix), .cam_cmd_data(cd), .cam_cmd_set_valid(sv),
        .cam_rsp_valid(rv), .cam_rsp_data(rd), .cam_rsp_entry_valid(rev),
        .cam_rsp_hit(rh), .cam_rsp_index(ri), .cam_match_hit(mh),
        .cam_match_index(mi), .cam_match_src(ms), .sysif_rx_data(sd),
        .sysif_rx_valid(rxv), .sysif_rx_start(rs), .timer_load_low_wr(tst[0]),
        .timer_load_high_wr(tst[1]), .timer_value_low_rd(tst[2]),
        .timer_value_high_rd(tst[3]), .timer_wdata(wd),
        .timer_flag_clr(fc), .timer_irq_en(ie), .timer_rdata(trd),
        .timer_expired_flag(ef), .timer_irq(irq), .porta_wr(rq[0]),
        .porta_addr(8'h11), .porta_wdata(qd), .sysif_ctl_wr(rq[1]),
        .sysif_ctl_addr(8'h22), .sysif_ctl_wdata(qd), .ctlcmd_wr(rq[2]),
        .ctlcmd_addr(8'h33), .ctlcmd_wdata(qd), .macreg_wr(mw),
        .macreg_addr(ma), .macreg_wdata(), .macreg_ack(ack));
    // ======================================================
    // Clock, hang guard and hit counter
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (mh === 1'b1) hits++;
        if (rs === 1'b1) starts++;
        if (rxv === 1'b1) rx_bytes++;
        if (cyc == 40000) begin
            err_total++;
            final_report();
        end
    end
    task automatic final_report();
        if (err_total == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [47:0] s, e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    // ======================================================
    // Access tasks: one-cycle command, answer on the next edge
    task automatic cmd(input logic [3:0] o, input logic [5:0] i,
        input logic [47:0] d, input logic v);
        @(posedge mclk);
        cv <= 1'b1;
        op <= o;
        ix <= i;
        cd <= d;
        sv <= v;
        @(posedge mclk);
        cv <= 1'b0;
        #1;
        chk("rsp_valid", rv, 1'b1);
    endtask
    task automatic tp(input logic [3:0] s, input logic [7:0] d, input logic c);
        @(posedge mclk);
        tst <= s;
        wd <= d;
        fc <= c;
        @(posedge mclk);
        tst <= 4'h0;
        fc <= 1'b0;
    endtask
    task automatic frame(input logic [47:0] da, sa);
        for (int k = 0; k < 12; k++)
            u_mac.send(k < 6 ? da[47-8*k -: 8] : sa[95-8*k -: 8], k == 0);
        repeat (12) @(posedge mclk);
    endtask
    task automatic ticks(input int n);
        repeat (n) u_mac.send(8'h00, 1'b0);
        repeat (12) @(posedge mclk);
    endtask
    // ======================================================
    // Main sequence
    initial begin
        {reset_n, ext, cv, sv, fc, ie} = 6'h00;
        {op, ix, cd, tst, wd, rq, qd} = '0;
        repeat (16) @(posedge mclk);
        reset_n <= 1'b1;
        cmd(4'h2, 6'h05, 48'h0, 1'b0);
        chk("valid_after_reset", rev, 1'b0);
        cmd(4'h1, 6'h05, 48'hA1B2C3D4E5F6, 1'b1);
        cmd(4'h2, 6'h05, 48'h0, 1'b0);
        chk("read_data", rd, 48'hA1B2C3D4E5F6);
        chk("read_valid", rev, 1'b1);
        cmd(4'h8, 6'h00, 48'hA1B2C3D4E5F6, 1'b0);
        chk("cmp_hit", {rh, ri}, {1'b1, 6'h05});
        ext <= 1'b1;
        hits = 0;
        frame(48'hA1B2C3D4E5F6, 48'h010203040506);
        frame(48'h010203040506, 48'hA1B2C3D4E5F6);
        chk("ext_hits", hits, 1);
        ext <= 1'b0;
        frame(48'h010203040506, 48'hA1B2C3D4E5F6);
        chk("src_hit", {hits[1:0], ms, mi}, {2'h2, 1'b1, 6'h05});
        chk("rx_last_byte", sd, 8'hF6);
        chk("rx_starts", starts, 3);
        chk("rx_bytes", rx_bytes, 36);
        cmd(4'h4, 6'h05, 48'h0, 1'b0);
        cmd(4'h8, 6'h00, 48'hA1B2C3D4E5F6, 1'b0);
        chk("cmp_cleared", rh, 1'b0);
        ie <= 1'b1;
        tp(4'h1, 8'h01, 1'b0);
        tp(4'h2, 8'h00, 1'b0);
        ticks(505);
        chk("no_early_expiry", ef, 1'b0);
        ticks(9);
        chk("expiry", {ef, irq}, 2'h3);
        tp(4'h0, 8'h00, 1'b1);
        ticks(520);
        chk("reload", ef, 1'b1);
        tp(4'h1, 8'h05, 1'b1);
        tp(4'h4, 8'h00, 1'b0);
        #1;
        chk("count_low", trd, 8'h01);
        ticks(600);
        chk("halted", ef, 1'b0);
        tp(4'h8, 8'h00, 1'b0);
        #1;
        chk("count_high", trd, 8'h00);
        tp(4'h4, 8'h00, 1'b0);
        #1;
        chk("count_frozen", trd, 8'h01);
        @(posedge mclk);
        rq <= 3'h5;
        @(posedge mclk);
        rq <= 3'h4;
        #1;
        chk("grant_port_a", {ack, ma}, {3'h1, 8'h11});
        @(posedge mclk);
        rq <= 3'h0;
        #1;
        chk("grant_cmd", {ack, ma, mw}, {3'h4, 8'h33, 1'b1});
        @(posedge mclk);
        #1;
        chk("grant_idle", {ack, mw}, 4'h0);
        final_report();
    end
endmodule
